// >>> hw/bsse_pkg.sv
// package: constants, op codes, states and carriers of the branch/skip/shift execution unit
package bsse_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W      = 8;
    localparam logic [7:0]  OFS_CMD     = 8'h00;
    localparam logic [7:0]  OFS_GPR     = 8'h04;
    localparam logic [7:0]  OFS_FLAGS   = 8'h08;
    localparam logic [7:0]  OFS_PC      = 8'h0C;
    localparam logic [7:0]  OFS_STATE   = 8'h10;
    localparam logic [7:0]  OFS_IO_BASE = 8'h80;
    localparam int unsigned IO_REGS     = 32;
    localparam int unsigned CMD_W       = 24;

    // ------------------------------------------------------------
    // status flag bit positions
    // ------------------------------------------------------------
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_I = 7;

    // state register field positions
    localparam int unsigned STATE_BUSY   = 0;
    localparam int unsigned STATE_TAKEN  = 1;
    localparam int unsigned STATE_CYC_LO = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  GPR_RST   = 8'h00;
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [7:0]  IO_RST    = 8'h00;

    // ------------------------------------------------------------
    // cycle counts and program counter steps
    // ------------------------------------------------------------
    localparam logic [1:0]  CYC_ONE    = 2'h1;
    localparam logic [1:0]  CYC_TAKEN  = 2'h2;
    localparam logic [1:0]  CYC_SKIP1  = 2'h2;
    localparam logic [1:0]  CYC_SKIP2  = 2'h3;
    localparam logic [1:0]  CYC_IO_BIT = 2'h2;
    localparam logic [15:0] PC_STEP    = 16'h0001;
    localparam logic [15:0] PC_SKIP1   = 16'h0002;
    localparam logic [15:0] PC_SKIP2   = 16'h0003;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_SKIP_IF_REG_BIT_ONE     = 5'h00,
        OP_SKIP_IF_IO_BIT_ZERO     = 5'h01,
        OP_SKIP_IF_IO_BIT_ONE      = 5'h02,
        OP_BRANCH_FLAG_INDEX_SET   = 5'h03,
        OP_BRANCH_FLAG_INDEX_CLEAR = 5'h04,
        OP_BRANCH_EQUAL            = 5'h05,
        OP_BRANCH_NOT_EQUAL        = 5'h06,
        OP_BRANCH_CARRY_ONE        = 5'h07,
        OP_BRANCH_CARRY_ZERO       = 5'h08,
        OP_BRANCH_UNSIGNED_GE      = 5'h09,
        OP_BRANCH_UNSIGNED_LT      = 5'h0A,
        OP_BRANCH_NEGATIVE         = 5'h0B,
        OP_BRANCH_NONNEGATIVE      = 5'h0C,
        OP_BRANCH_SIGNED_GE        = 5'h0D,
        OP_BRANCH_SIGNED_LT        = 5'h0E,
        OP_BRANCH_HALF_CARRY_ONE   = 5'h0F,
        OP_BRANCH_HALF_CARRY_ZERO  = 5'h10,
        OP_BRANCH_TRANSFER_BIT_ONE = 5'h11,
        OP_BRANCH_TRANSFER_BIT_ZERO= 5'h12,
        OP_BRANCH_OVERFLOW_ONE     = 5'h13,
        OP_BRANCH_OVERFLOW_ZERO    = 5'h14,
        OP_BRANCH_IRQ_ENABLED      = 5'h15,
        OP_BRANCH_IRQ_DISABLED     = 5'h16,
        OP_IO_BIT_SET              = 5'h17,
        OP_IO_BIT_CLEAR            = 5'h18,
        OP_SHIFT_LEFT_LOGICAL      = 5'h19,
        OP_SHIFT_RIGHT_LOGICAL     = 5'h1A,
        OP_ROTATE_LEFT_VIA_CARRY   = 5'h1B,
        OP_ROTATE_RIGHT_VIA_CARRY  = 5'h1C
    } bsse_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_EXEC = 2'h2
    } bsse_state_e;

    // command word as written to the command register, bit 0 at op[0]
    typedef struct packed {
        logic [4:0] io_addr;
        logic       two_word;
        logic [6:0] offset;
        logic [2:0] flag_sel;
        logic [2:0] bit_sel;
        bsse_op_e   op;
    } bsse_cmd_s;

    // outcome of one instruction, applied when its last cycle ends
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0]  flags;
        logic [7:0]  gpr;
        logic [7:0]  io_val;
        logic        io_we;
        logic        taken;
        logic [1:0]  cycles;
    } bsse_result_s;

endpackage

// >>> hw/bsse_exec.sv
// module: execution unit for skips, flag branches, i/o bit writes and shifts, avalon-mm slave
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns

// How it works
// RULE_01: skip next instruction when chosen general register bit is one; flags kept.
// RULE_02: skip next instruction when chosen i/o register bit reads zero; flags kept.
// RULE_03: i/o skip companion skips when chosen i/o bit reads one.
// RULE_04: skip over one-word: pc plus two, two cycles; two-word: plus three, three.
// RULE_05: index branch jumps to pc plus offset plus one when selected flag is one.
// RULE_06: index branch on clear flag jumps when flag is zero; one or two cycles.
// RULE_07: equal branch on zero flag one, not-equal branch on zero flag zero.
// RULE_08: carry branches test carry; unsigned ge on carry zero, lt on one.
// RULE_09: minus branch on negative one, plus branch on negative zero.
// RULE_10: signed ge when negative xor overflow zero, signed lt when it is one.
// RULE_11: half-carry branches on half-carry one or zero.
// RULE_12: transfer-bit branches on t bit one or zero.
// RULE_13: overflow branches on overflow one or zero.
// RULE_14: interrupt-state branches on global enable one or zero; no flag changes.
// RULE_15: branches take one cycle untaken, two taken, never touch flags.
// RULE_16: i/o bit set writes one to chosen bit, two cycles, flags kept.
// RULE_17: i/o bit clear writes zero to chosen bit, two cycles, flags kept.
// RULE_18: shift left inserts zero at bit 0, one cycle, updates z c n v.
// RULE_19: shift right loads zero into bit 7, one cycle, updates z c n v.
// RULE_20: rotate left puts carry in bit 0, bit 7 in carry, one cycle.
// RULE_21: rotate right puts carry in bit 7, bit 0 in carry, one cycle.
module bsse_exec
    import bsse_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------

    // true for every op that is a conditional relative branch
    function automatic logic is_branch(input bsse_op_e op);
        is_branch = (op >= OP_BRANCH_FLAG_INDEX_SET) && (op <= OP_BRANCH_IRQ_DISABLED);
    endfunction

    // branch condition for the given flags
    function automatic logic branch_taken(input bsse_op_e op, input logic [7:0] f,
                                          input logic [2:0] sel);
        case (op)
            OP_BRANCH_FLAG_INDEX_SET:    branch_taken = f[sel];              // RULE_05
            OP_BRANCH_FLAG_INDEX_CLEAR:  branch_taken = !f[sel];             // RULE_06
            OP_BRANCH_EQUAL:             branch_taken = f[FLAG_Z];           // RULE_07
            OP_BRANCH_NOT_EQUAL:         branch_taken = !f[FLAG_Z];          // RULE_07
            OP_BRANCH_CARRY_ONE,
            OP_BRANCH_UNSIGNED_LT:       branch_taken = f[FLAG_C];           // RULE_08
            OP_BRANCH_CARRY_ZERO,
            OP_BRANCH_UNSIGNED_GE:       branch_taken = !f[FLAG_C];          // RULE_08
            OP_BRANCH_NEGATIVE:          branch_taken = f[FLAG_N];           // RULE_09
            OP_BRANCH_NONNEGATIVE:       branch_taken = !f[FLAG_N];          // RULE_09
            OP_BRANCH_SIGNED_GE:         branch_taken = !(f[FLAG_N] ^ f[FLAG_V]); // RULE_10
            OP_BRANCH_SIGNED_LT:         branch_taken = f[FLAG_N] ^ f[FLAG_V];    // RULE_10
            OP_BRANCH_HALF_CARRY_ONE:    branch_taken = f[FLAG_H];           // RULE_11
            OP_BRANCH_HALF_CARRY_ZERO:   branch_taken = !f[FLAG_H];          // RULE_11
            OP_BRANCH_TRANSFER_BIT_ONE:  branch_taken = f[FLAG_T];           // RULE_12
            OP_BRANCH_TRANSFER_BIT_ZERO: branch_taken = !f[FLAG_T];          // RULE_12
            OP_BRANCH_OVERFLOW_ONE:      branch_taken = f[FLAG_V];           // RULE_13
            OP_BRANCH_OVERFLOW_ZERO:     branch_taken = !f[FLAG_V];          // RULE_13
            OP_BRANCH_IRQ_ENABLED:       branch_taken = f[FLAG_I];           // RULE_14
            OP_BRANCH_IRQ_DISABLED:      branch_taken = !f[FLAG_I];          // RULE_14
            default:                     branch_taken = 1'b0;
        endcase
    endfunction

    // full outcome of one command against the current state
    function automatic bsse_result_s execute(input bsse_cmd_s c, input logic [15:0] pc,
                                             input logic [7:0] f, input logic [7:0] r,
                                             input logic [7:0] io);
        bsse_result_s res;
        logic         skip;
        logic         cout;
        logic [7:0]   sh;
        res       = '{pc: pc + PC_STEP, flags: f, gpr: r, io_val: io, io_we: 1'b0,
                      taken: 1'b0, cycles: CYC_ONE};
        skip      = 1'b0;
        cout      = 1'b0;
        sh        = r;
        case (c.op)
            OP_SKIP_IF_REG_BIT_ONE: skip = r[c.bit_sel];                     // RULE_01
            OP_SKIP_IF_IO_BIT_ZERO: skip = !io[c.bit_sel];                   // RULE_02
            OP_SKIP_IF_IO_BIT_ONE:  skip = io[c.bit_sel];                    // RULE_03
            OP_IO_BIT_SET: begin
                res.io_val[c.bit_sel] = 1'b1;                                // RULE_16
                res.io_we             = 1'b1;
                res.cycles            = CYC_IO_BIT;
            end
            OP_IO_BIT_CLEAR: begin
                res.io_val[c.bit_sel] = 1'b0;                                // RULE_17
                res.io_we             = 1'b1;
                res.cycles            = CYC_IO_BIT;
            end
            OP_SHIFT_LEFT_LOGICAL: begin
                sh   = {r[6:0], 1'b0};                                       // RULE_18
                cout = r[7];
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
                sh   = {1'b0, r[7:1]};                                       // RULE_19
                cout = r[0];
            end
            OP_ROTATE_LEFT_VIA_CARRY: begin
                sh   = {r[6:0], f[FLAG_C]};                                  // RULE_20
                cout = r[7];
            end
            OP_ROTATE_RIGHT_VIA_CARRY: begin
                sh   = {f[FLAG_C], r[7:1]};                                  // RULE_21
                cout = r[0];
            end
            default: begin
                // branches: flags untouched, two cycles when taken
                if (is_branch(c.op) && branch_taken(c.op, f, c.flag_sel)) begin
                    res.pc     = pc + {{9{c.offset[6]}}, c.offset} + PC_STEP; // RULE_05
                    res.taken  = 1'b1;
                    res.cycles = CYC_TAKEN;                                  // RULE_15
                end
            end
        endcase
        // skip length follows the size of the skipped instruction
        if (skip) begin
            res.taken  = 1'b1;
            res.pc     = pc + (c.two_word ? PC_SKIP2 : PC_SKIP1);            // RULE_04
            res.cycles = c.two_word ? CYC_SKIP2 : CYC_SKIP1;                 // RULE_04
        end
        // shift family: result and z c n v, v is n xor c
        if (c.op >= OP_SHIFT_LEFT_LOGICAL && c.op <= OP_ROTATE_RIGHT_VIA_CARRY) begin
            res.gpr          = sh;
            res.flags[FLAG_Z] = (sh == 8'h00);                               // RULE_18
            res.flags[FLAG_C] = cout;
            res.flags[FLAG_N] = sh[7];
            res.flags[FLAG_V] = sh[7] ^ cout;
        end
        execute = res;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]   io_mem [IO_REGS];
    logic [15:0]  pc;
    logic [7:0]   flags;
    logic [7:0]   gpr;
    bsse_cmd_s    cmd;
    bsse_result_s pend;
    bsse_state_e  state;
    logic [1:0]   cnt;
    logic         last_taken;
    logic [1:0]   last_cycles;

    // bus decode
    bsse_cmd_s    cmd_in;
    bsse_result_s next_res;
    logic         bus_req;
    logic         bus_done;
    logic         wr_done;
    logic         io_sel;
    logic [4:0]   io_idx;
    logic         launch;
    logic         commit;

    assign bus_req  = avs_read_i || avs_write_i;
    assign bus_done = bus_req && !avs_waitrequest_o;
    assign wr_done  = bus_done && avs_write_i;
    assign io_sel   = avs_address_i[7];
    assign io_idx   = avs_address_i[6:2];
    assign cmd_in   = bsse_cmd_s'(avs_writedata_i[CMD_W-1:0]);
    assign launch   = wr_done && (avs_address_i == OFS_CMD);
    assign commit   = (state == ST_EXEC) && (cnt == CYC_ONE);
    assign next_res = execute(cmd_in, pc, flags, gpr, io_mem[cmd_in.io_addr]);

    // ------------------------------------------------------------
    // avalon slave: waitrequest drops one cycle after a request
    // while idle; read data is loaded at that same edge
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else if (bus_req && avs_waitrequest_o && state == ST_IDLE) begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= 32'h0000_0000;
            if (avs_read_i && io_sel) begin
                avs_readdata_o[7:0] <= io_mem[io_idx];
            end else if (avs_read_i) begin
                case (avs_address_i)
                    OFS_CMD:   avs_readdata_o[CMD_W-1:0] <= cmd;
                    OFS_GPR:   avs_readdata_o[7:0]       <= gpr;
                    OFS_FLAGS: avs_readdata_o[7:0]       <= flags;
                    OFS_PC:    avs_readdata_o[15:0]      <= pc;
                    OFS_STATE: begin
                        avs_readdata_o[STATE_BUSY]                 <= 1'b0;
                        avs_readdata_o[STATE_TAKEN]                <= last_taken;
                        avs_readdata_o[STATE_CYC_LO+1:STATE_CYC_LO] <= last_cycles;
                    end
                    default:   avs_readdata_o <= 32'h0000_0000;
                endcase
            end
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // sequencer: holds the bus off for the instruction's cycles
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state       <= ST_IDLE;
            cnt         <= CYC_ONE;
            cmd         <= '0;
            pend        <= '0;
            last_taken  <= 1'b0;
            last_cycles <= CYC_ONE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (launch) begin
                        cmd   <= cmd_in;
                        pend  <= next_res;
                        cnt   <= next_res.cycles;
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (commit) begin
                        last_taken  <= pend.taken;
                        last_cycles <= pend.cycles;
                        state       <= ST_IDLE;
                    end else begin
                        cnt <= cnt - CYC_ONE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // program counter: software load when idle, update at commit
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pc <= PC_RST;
        end else if (commit) begin
            pc <= pend.pc;                                                   // RULE_15
        end else if (wr_done && avs_address_i == OFS_PC) begin
            if (avs_byteenable_i[0]) pc[7:0]  <= avs_writedata_i[7:0];
            if (avs_byteenable_i[1]) pc[15:8] <= avs_writedata_i[15:8];
        end
    end

    // status flags: only shifts change them at commit
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            flags <= FLAGS_RST;
        end else if (commit) begin
            flags <= pend.flags;                                             // RULE_19
        end else if (wr_done && avs_address_i == OFS_FLAGS && avs_byteenable_i[0]) begin
            flags <= avs_writedata_i[7:0];
        end
    end

    // working register under test or shift
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            gpr <= GPR_RST;
        end else if (commit) begin
            gpr <= pend.gpr;                                                 // RULE_20
        end else if (wr_done && avs_address_i == OFS_GPR && avs_byteenable_i[0]) begin
            gpr <= avs_writedata_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // i/o register file, one process per location
    // ------------------------------------------------------------
    for (genvar g = 0; g < IO_REGS; g++) begin : g_io
        always_ff @(posedge clk_sys_i) begin
            if (reset_i) begin
                io_mem[g] <= IO_RST;
            end else if (commit && pend.io_we && cmd.io_addr == 5'(g)) begin
                io_mem[g] <= pend.io_val;                                    // RULE_16
            end else if (wr_done && io_sel && io_idx == 5'(g) && avs_byteenable_i[0]) begin
                io_mem[g] <= avs_writedata_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [15:0] snap_pc;
    logic [7:0]  snap_flags;
    logic [7:0]  snap_gpr;

    // values at launch, read only by the checks
    always_ff @(posedge clk_sys_i) begin
        if (launch) begin
            snap_pc    <= pc;
            snap_flags <= flags;
            snap_gpr   <= gpr;
        end
    end

    a_skip_reg_bit: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_01
        launch && cmd_in.op == OP_SKIP_IF_REG_BIT_ONE && gpr[cmd_in.bit_sel] && !cmd_in.two_word
        |-> ##3 (pc == snap_pc + PC_SKIP1) && (flags == snap_flags))
        else $error("register bit skip wrong pc or flags");

    a_skip_io_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_02
        launch && cmd_in.op == OP_SKIP_IF_IO_BIT_ZERO && cmd_in.two_word
        && !io_mem[cmd_in.io_addr][cmd_in.bit_sel]
        |=> (state == ST_EXEC) [*3] ##1 (state == ST_IDLE) && (pc == snap_pc + PC_SKIP2))
        else $error("io zero skip over two words wrong");

    a_skip_io_one: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_03
        launch && cmd_in.op == OP_SKIP_IF_IO_BIT_ONE && !io_mem[cmd_in.io_addr][cmd_in.bit_sel]
        |-> ##2 (pc == snap_pc + PC_STEP) && (last_cycles == CYC_ONE))
        else $error("io one skip taken on zero bit");

    a_branch_taken: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_05
        launch && is_branch(cmd_in.op) && branch_taken(cmd_in.op, flags, cmd_in.flag_sel)
        |-> ##3 (pc == snap_pc + {{9{cmd.offset[6]}}, cmd.offset} + PC_STEP)
             && (flags == snap_flags))
        else $error("taken branch wrong target or flags");

    a_branch_untaken: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_15
        launch && is_branch(cmd_in.op) && !branch_taken(cmd_in.op, flags, cmd_in.flag_sel)
        |=> (state == ST_EXEC) ##1 (state == ST_IDLE) && (pc == snap_pc + PC_STEP))
        else $error("untaken branch not one cycle");

    a_io_set_bit: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_16
        launch && cmd_in.op == OP_IO_BIT_SET
        |-> ##3 io_mem[cmd.io_addr][cmd.bit_sel] && (flags == snap_flags)
             && (last_cycles == CYC_IO_BIT))
        else $error("io bit set failed");

    a_io_clear_bit: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_17
        launch && cmd_in.op == OP_IO_BIT_CLEAR
        |-> ##3 !io_mem[cmd.io_addr][cmd.bit_sel] && (flags == snap_flags))
        else $error("io bit clear failed");

    a_shift_left: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_18
        launch && cmd_in.op == OP_SHIFT_LEFT_LOGICAL
        |-> ##2 (gpr == {snap_gpr[6:0], 1'b0}) && (flags[FLAG_C] == snap_gpr[7])
             && (flags[FLAG_Z] == (snap_gpr[6:0] == 7'h00)))
        else $error("logical left shift wrong");

    a_rotate_right: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_21
        launch && cmd_in.op == OP_ROTATE_RIGHT_VIA_CARRY
        |-> ##2 (gpr == {snap_flags[FLAG_C], snap_gpr[7:1]}) && (flags[FLAG_C] == snap_gpr[0]))
        else $error("rotate right through carry wrong");

    a_skip_two_word: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_04
        launch && cmd_in.op == OP_SKIP_IF_REG_BIT_ONE && gpr[cmd_in.bit_sel] && cmd_in.two_word
        |-> ##4 (pc == snap_pc + PC_SKIP2) && (last_cycles == CYC_SKIP2)
             && (flags == snap_flags))
        else $error("register bit skip over two words wrong");

    a_shift_right: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_19
        launch && cmd_in.op == OP_SHIFT_RIGHT_LOGICAL
        |-> ##2 (gpr == {1'b0, snap_gpr[7:1]}) && (flags[FLAG_C] == snap_gpr[0])
             && !flags[FLAG_N])
        else $error("logical right shift wrong");

    a_rotate_left: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_20
        launch && cmd_in.op == OP_ROTATE_LEFT_VIA_CARRY
        |-> ##2 (gpr == {snap_gpr[6:0], snap_flags[FLAG_C]}) && (flags[FLAG_C] == snap_gpr[7])
             && (flags[FLAG_V] == (snap_gpr[6] ^ snap_gpr[7])))
        else $error("rotate left through carry wrong");

endmodule

// >>> test/bsse_prog_mem.sv
// program memory model: hands the fetch path the command word at the program counter
`timescale 1ns/1ns
module bsse_prog_mem
    import bsse_pkg::*;
(
    input  wire logic [15:0] pc_i,
    output bsse_cmd_s        cmd_o
);
    bsse_cmd_s rom [16]; // program words, loaded by the bench
    // combinational fetch of the word at the current pc
    assign cmd_o = rom[pc_i[3:0]];
endmodule

// >>> test/test_branch_skip_shift_exec.sv
// self-checking bench: runs each instruction through the register bus
`timescale 1ns/1ns
module test_branch_skip_shift_exec;
    import bsse_pkg::*;
    logic        clk_sys_i = 0, reset_i = 1, rd = 0, wr = 0, wreq, t;
    logic [7:0]  adr = 0, f;
    logic [31:0] wd = 0, rdat, q, pcv, flv, stv;
    logic [15:0] fpc = 0;
    bsse_cmd_s   cmd;
    int          err_total = 0, n_tests = 0, op, j;
    localparam logic [47:0] XD = 48'h8380_0240_03c0;
    localparam logic [47:0] XF = 48'he1e1_e9e9_e9e5;
    always #25 clk_sys_i = ~clk_sys_i;
    bsse_exec DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq));
    bsse_prog_mem pm (.pc_i(fpc), .cmd_o(cmd));
    // verdict and counts
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus access, held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        adr <= a;
        rd <= !w;
        wr <= w;
        wd <= d;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wreq !== 1'b0 && n < 200);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wreq !== 1'b0) begin
            err_total++;
            give_verdict;
        end
    endtask
    // load flags, register, i/o 3 and pc 0, fetch and launch, read back
    task automatic ex(input int o, input logic [7:0] fl, input logic [7:0] g,
                      input logic [2:0] b, input logic tw);
        pm.rom[0] = {5'h03, tw, 7'h7e, o[2:0], b, o[4:0]};
        acc(1, OFS_FLAGS, {24'h0, fl});
        acc(1, OFS_GPR, {24'h0, g});
        acc(1, 8'h8c, {24'h0, g});
        acc(1, OFS_PC, 0);
        fpc = 16'h0000;
        acc(1, OFS_CMD, {8'h00, cmd});
        acc(0, OFS_PC, 0);
        pcv = q;
        acc(0, OFS_FLAGS, 0);
        flv = q;
        acc(0, OFS_STATE, 0);
        stv = q;
    endtask
    // branch condition worked out from the flags
    function automatic logic tk(input int o, input logic [7:0] x);
        logic [8:0] c;
        c = {x[7], x[3], x[6], x[5], x[2] ^ x[3], x[2], x[0], x[0], x[1]};
        if (o < 5) return x[o[2:0]] ^ (o == 4);
        return c[(o - 5) / 2] ^ ~o[0] ^ (o == 9 || o == 10 || o == 13 || o == 14);
    endfunction
    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        acc(0, OFS_PC, 0);
        chk(q, 0);
        acc(0, 8'h40, 0);
        chk(q, 0);
        $display("reset and unmapped read done");
        for (op = 3; op < 23; op++) for (j = 0; j < 3; j++) begin
            f = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'h04;
            ex(op, f, 8'h00, 3'h0, 1'b0);
            t = tk(op, f);
            chk(pcv, t ? 32'h0000_ffff : 32'h0000_0001);
            chk(flv, {24'h0, f});
            chk(stv[3:1], {t ? 2'h2 : 2'h1, t});
        end
        $display("branches done");
        for (op = 0; op < 12; op++) begin
            ex(op / 4, 8'h5a, op[0] ? 8'h20 : 8'hdf, 3'h5, op[1]);
            t = op[0] ^ (op / 4 == 1);
            chk(pcv, t ? 32'h2 + op[1] : 32'h1);
            chk(flv, 32'h5a);
            chk(stv[3:2], t ? 2'h2 + op[1] : 2'h1);
        end
        $display("skips done");
        for (op = 23; op < 29; op++) begin
            ex(op, 8'he1, 8'h81, op == 23, 1'b0);
            acc(0, op < 25 ? 8'h8c : OFS_GPR, 0);
            chk(q, XD[8 * (28 - op) +: 8]);
            chk(flv, XF[8 * (28 - op) +: 8]);
            chk(stv[3:2], op < 25 ? 2'h2 : 2'h1);
            chk(pcv, 1);
        end
        $display("bit writes and shifts done");
        give_verdict;
    end
endmodule
